// File: inc/spr_pkg.sv
// Shared constants and types for the two-channel setpoint relay controller.
// Assumes a 100 MHz system clock and an AHB-Lite register port.
package spr_pkg;
   // Clock and timing figures
   localparam int CLK_MHZ = 100;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;
   localparam int SHOW_S = 5;
   localparam int SHOW_MS = SHOW_S * 1000;
   localparam int SAVE_S = 5;
   localparam int SAVE_MS = SAVE_S * 1000;
   localparam int FINE_S = 1;
   localparam int FINE_MS = FINE_S * 1000;
   localparam int STEP_MS = 100;
   localparam int VERSION_MS = 2000;
   localparam int BLINK_MS = 250;

   // Register map: channel n sits at n * 16
   localparam logic [3:0] CH_LOW_THR = 4'h0;
   localparam logic [3:0] CH_HIGH_THR = 4'h4;
   localparam logic [3:0] CH_CFG = 4'h8;
   localparam logic [3:0] CH_STAT = 4'hC;
   localparam logic [7:0] GLOBAL_STAT = 8'h20;

   // Configuration word fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_LOW_EN = 2;
   localparam int CFG_HIGH_EN = 3;
   localparam int CFG_LOW_HYST_LSB = 8;
   localparam int CFG_HIGH_HYST_LSB = 16;

   // Reset values, threshold maximum and percent divisor
   localparam logic [15:0] THR_LOW_RST = 16'h0000;
   localparam logic [15:0] THR_HIGH_RST = 16'hFFFF;
   localparam logic [15:0] THR_MAX = 16'hFFFF;
   localparam logic [7:0] HYST_RST = 8'h0A;
   localparam logic [23:0] PCT_DIV = 24'h00_0064;

   typedef enum logic [1:0] {
      MODE_LOW = 2'h0,
      MODE_HIGH = 2'h1,
      MODE_BOTH = 2'h2
   } spr_mode_type;

   typedef enum logic [2:0] {
      ST_MEAS,
      ST_SHOW,
      ST_RAMP,
      ST_FINE,
      ST_WAIT
   } spr_state_type;

   typedef struct packed {
      logic [15:0] low_thr;
      logic [15:0] high_thr;
      spr_mode_type mode;
      logic low_en;
      logic high_en;
      logic [7:0] low_hyst;
      logic [7:0] high_hyst;
   } spr_cfg_type;
endpackage : spr_pkg

// File: rtl/spr_top.sv
// Two-channel pressure setpoint switching: trip compare with hysteresis,
// pushbutton threshold adjustment, value output mux, status lamp, AHB-Lite regs.
// Assumes pressure and fault inputs come from logic on sys_clk_i; buttons are pins.
// Functional notes
// - Low-trip mode closes relay and lights lamp while pressure below threshold.
// - High-trip mode closes relay and lights lamp while pressure above threshold.
// - Combined mode trips above the upper or below the lower threshold.
// - Reset gives low-trip mode with threshold at range bottom; never switches.
// - Two independent channels, each with its own relay output.
// - While a channel is being adjusted, the value output carries its threshold; channel 0 wins if both are.
// - Held press enters adjust mode, shows threshold about 5 s, blinks indicator.
// - Continued holding steps threshold toward its limit until release or limit.
// - Renewed press inside the fine window moves the threshold one step.
// - Renewed press outside the fine window reverses the holding direction.
// - Release longer than 5 s stores the threshold and returns to measuring.
// - Default hysteresis is 10 percent on both trip points.
// - Any button adjustment restores that channel's hysteresis to 10 percent.
// - In combined mode the button moves only the lower threshold.
// - Mode changes only through the register port; hysteresis also returns to 10 percent on a button press.
// - Each channel holds thresholds, enables, hysteresis values and a mode.
// - Status lamp green when fault-free, red steady or blinking on faults.
// - Second channel adjusts with the same sequence and timing as the first.
// - After power-up the firmware version is shown briefly before measuring.
// - Each threshold is readable and writable by the host port.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module spr_top #(
   parameter int MS_CYCLES = spr_pkg::TICK_CYCLES,
   parameter int SHOW_MS = spr_pkg::SHOW_MS,
   parameter int SAVE_MS = spr_pkg::SAVE_MS,
   parameter int FINE_MS = spr_pkg::FINE_MS,
   parameter int STEP_MS = spr_pkg::STEP_MS,
   parameter int VERSION_MS = spr_pkg::VERSION_MS,
   parameter int BLINK_MS = spr_pkg::BLINK_MS,
   // Arbitrary firmware version code
   parameter logic [7:0] FW_VERSION = 8'h01
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // Measurement and faults
   input wire logic [15:0] pressure_i,
   input wire logic fault_fatal_i,
   input wire logic fault_soft_i,
   // Buttons
   input wire logic setpoint_one_btn_i,
   input wire logic setpoint_two_btn_i,
   // Outputs
   output logic [1:0] relay_o,
   output logic [1:0] sp_lamp_o,
   output logic [1:0] switch_ind_o,
   output logic [1:0] nv_store_o,
   output logic [15:0] meas_value_o,
   output logic status_lamp_green_o,
   output logic status_lamp_red_o,
   output logic version_show_o
);
   spr_pkg::spr_cfg_type cfg [2];
   logic [1:0] adj;
   logic [1:0] low_on;
   logic [1:0] high_on;
   logic [1:0] dir_up;
   logic [15:0] sel_thr [2];
   logic [1:0] btn_raw;
   logic ms_tick;
   logic [31:0] ms_cnt;
   logic [15:0] blink_cnt;
   logic blink;
   logic [15:0] ver_cnt;
   logic wr_pend;
   logic rd_pend;
   logic [7:0] bus_addr;
   logic [31:0] rd_word;

   assign btn_raw = {setpoint_two_btn_i, setpoint_one_btn_i};

   // Millisecond tick shared by every timer
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ms_cnt <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
         ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         blink_cnt <= 16'h0000;
         blink <= 1'b0;
      end else if (ms_tick) begin
         blink_cnt <= (blink_cnt >= 16'(BLINK_MS - 1)) ? 16'h0000 : blink_cnt + 16'h0001;
         if (blink_cnt >= 16'(BLINK_MS - 1)) begin
            blink <= ~blink;
         end
      end
   end

   // Version display window; buttons stay ignored until it closes
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ver_cnt <= 16'h0000;
         version_show_o <= 1'b1;
      end else if (ms_tick && version_show_o) begin
         ver_cnt <= ver_cnt + 16'h0001;
         version_show_o <= (ver_cnt < 16'(VERSION_MS - 1));
      end
   end

   // Channel 0 wins the output when both are adjusted
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         meas_value_o <= 16'h0000;
      end else begin
         meas_value_o <= adj[0] ? sel_thr[0] : adj[1] ? sel_thr[1] : pressure_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         status_lamp_green_o <= 1'b0;
         status_lamp_red_o <= 1'b0;
      end else begin
         status_lamp_green_o <= !(fault_fatal_i || fault_soft_i);
         status_lamp_red_o <= fault_fatal_i || (fault_soft_i && blink);
      end
   end

   for (genvar i = 0; i < 2; i++) begin : ch
      logic s1;
      logic s2;
      logic s3;
      logic btn;
      logic [15:0] tmr;
      logic [15:0] stepped;
      logic [23:0] low_margin;
      logic [23:0] high_margin;
      logic [17:0] low_rel;
      logic [17:0] high_rel;
      logic low_act;
      logic high_act;
      logic next_low_on;
      logic next_high_on;
      logic do_step;
      logic do_flip;
      logic do_rst;
      logic clr_tmr;
      logic store;
      logic adj_high;
      spr_pkg::spr_state_type state;
      spr_pkg::spr_state_type next_state;

      // Three-stage pin synchroniser; the level moves once stages two and three agree
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
         if (reset_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            btn <= 1'b0;
         end else begin
            s1 <= btn_raw[i];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
               btn <= s3;
            end
         end
      end

      // Combined mode moves the lower threshold only
      assign adj_high = (cfg[i].mode == spr_pkg::MODE_HIGH);
      assign sel_thr[i] = adj_high ? cfg[i].high_thr : cfg[i].low_thr;
      assign adj[i] = (state != spr_pkg::ST_MEAS);
      assign stepped = dir_up[i] ? ((sel_thr[i] == spr_pkg::THR_MAX) ? sel_thr[i] :
                       sel_thr[i] + 16'h0001) : ((sel_thr[i] == 16'h0000) ? sel_thr[i] :
                       sel_thr[i] - 16'h0001);

      always_comb begin
         next_state = state;
         do_step = 1'b0;
         do_flip = 1'b0;
         do_rst = 1'b0;
         clr_tmr = 1'b0;
         store = 1'b0;
         unique case (state)
            spr_pkg::ST_MEAS: begin
               if (btn && !version_show_o) begin
                  next_state = spr_pkg::ST_SHOW;
                  do_rst = 1'b1;
                  clr_tmr = 1'b1;
               end
            end
            spr_pkg::ST_SHOW: begin
               if (!btn) begin
                  next_state = spr_pkg::ST_WAIT;
                  clr_tmr = 1'b1;
               end else if (tmr >= 16'(SHOW_MS)) begin
                  next_state = spr_pkg::ST_RAMP;
                  clr_tmr = 1'b1;
               end
            end
            spr_pkg::ST_RAMP: begin
               if (!btn) begin
                  next_state = spr_pkg::ST_WAIT;
                  clr_tmr = 1'b1;
               end else if (ms_tick && tmr >= 16'(STEP_MS - 1)) begin
                  do_step = 1'b1;
                  clr_tmr = 1'b1;
               end
            end
            spr_pkg::ST_FINE: begin
               if (!btn) begin
                  next_state = spr_pkg::ST_WAIT;
                  clr_tmr = 1'b1;
               end
            end
            spr_pkg::ST_WAIT: begin
               if (btn) begin
                  clr_tmr = 1'b1;
                  do_rst = 1'b1;
                  if (tmr < 16'(FINE_MS)) begin
                     next_state = spr_pkg::ST_FINE;
                     do_step = 1'b1;
                  end else begin
                     next_state = spr_pkg::ST_RAMP;
                     do_flip = 1'b1;
                  end
               end else if (tmr > 16'(SAVE_MS)) begin
                  next_state = spr_pkg::ST_MEAS;
                  store = 1'b1;
               end
            end
         endcase
      end

      always_ff @(posedge sys_clk_i or posedge reset_i) begin
         if (reset_i) begin
            state <= spr_pkg::ST_MEAS;
            tmr <= 16'h0000;
            dir_up[i] <= 1'b1;
            nv_store_o[i] <= 1'b0;
            switch_ind_o[i] <= 1'b0;
         end else begin
            state <= next_state;
            nv_store_o[i] <= store;
            switch_ind_o[i] <= (next_state != spr_pkg::ST_MEAS) && blink;
            if (clr_tmr) begin
               tmr <= 16'h0000;
            end else if (ms_tick && tmr != 16'hFFFF) begin
               tmr <= tmr + 16'h0001;
            end
            if (state == spr_pkg::ST_MEAS && next_state == spr_pkg::ST_SHOW) begin
               dir_up[i] <= 1'b1;
            end else if (do_flip) begin
               dir_up[i] <= ~dir_up[i];
            end
         end
      end

      // Host writes land in the data phase; the button path is applied last and wins
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
         if (reset_i) begin
            cfg[i].low_thr <= spr_pkg::THR_LOW_RST;
            cfg[i].high_thr <= spr_pkg::THR_HIGH_RST;
            cfg[i].mode <= spr_pkg::MODE_LOW;
            cfg[i].low_en <= 1'b1;
            cfg[i].high_en <= 1'b1;
            cfg[i].low_hyst <= spr_pkg::HYST_RST;
            cfg[i].high_hyst <= spr_pkg::HYST_RST;
         end else begin
            if (wr_pend && bus_addr[7:4] == 4'(i)) begin
               if (bus_addr[3:0] == spr_pkg::CH_LOW_THR) begin
                  cfg[i].low_thr <= hwdata_i[15:0];
               end
               if (bus_addr[3:0] == spr_pkg::CH_HIGH_THR) begin
                  cfg[i].high_thr <= hwdata_i[15:0];
               end
               if (bus_addr[3:0] == spr_pkg::CH_CFG) begin
                  cfg[i].mode <= spr_pkg::spr_mode_type'(hwdata_i[spr_pkg::CFG_MODE_LSB +: 2]);
                  cfg[i].low_en <= hwdata_i[spr_pkg::CFG_LOW_EN];
                  cfg[i].high_en <= hwdata_i[spr_pkg::CFG_HIGH_EN];
                  cfg[i].low_hyst <= hwdata_i[spr_pkg::CFG_LOW_HYST_LSB +: 8];
                  cfg[i].high_hyst <= hwdata_i[spr_pkg::CFG_HIGH_HYST_LSB +: 8];
               end
            end
            if (do_rst) begin
               cfg[i].low_hyst <= spr_pkg::HYST_RST;
               cfg[i].high_hyst <= spr_pkg::HYST_RST;
            end
            if (do_step && adj_high) begin
               cfg[i].high_thr <= stepped;
            end else if (do_step) begin
               cfg[i].low_thr <= stepped;
            end
         end
      end

      // Release levels sit the hysteresis percentage beyond each trip point
      assign low_margin = (24'(cfg[i].low_thr) * 24'(cfg[i].low_hyst)) / spr_pkg::PCT_DIV;
      assign high_margin = (24'(cfg[i].high_thr) * 24'(cfg[i].high_hyst)) / spr_pkg::PCT_DIV;
      assign low_rel = 18'(cfg[i].low_thr) + low_margin[17:0];
      assign high_rel = (high_margin[17:0] > 18'(cfg[i].high_thr)) ? 18'h0_0000 :
                        18'(cfg[i].high_thr) - high_margin[17:0];
      assign low_act = (cfg[i].mode == spr_pkg::MODE_LOW || cfg[i].mode == spr_pkg::MODE_BOTH)
                       && cfg[i].low_en;
      assign high_act = (cfg[i].mode == spr_pkg::MODE_HIGH || cfg[i].mode == spr_pkg::MODE_BOTH)
                        && cfg[i].high_en;

      always_comb begin
         next_low_on = low_on[i];
         next_high_on = high_on[i];
         if (!low_act) begin
            next_low_on = 1'b0;
         end else if (pressure_i < cfg[i].low_thr) begin
            next_low_on = 1'b1;
         end else if (18'(pressure_i) > low_rel) begin
            next_low_on = 1'b0;
         end
         if (!high_act) begin
            next_high_on = 1'b0;
         end else if (pressure_i > cfg[i].high_thr) begin
            next_high_on = 1'b1;
         end else if (18'(pressure_i) < high_rel) begin
            next_high_on = 1'b0;
         end
      end

      always_ff @(posedge sys_clk_i or posedge reset_i) begin
         if (reset_i) begin
            low_on[i] <= 1'b0;
            high_on[i] <= 1'b0;
            relay_o[i] <= 1'b0;
            sp_lamp_o[i] <= 1'b0;
         end else begin
            low_on[i] <= next_low_on;
            high_on[i] <= next_high_on;
            relay_o[i] <= next_low_on || next_high_on;
            sp_lamp_o[i] <= next_low_on || next_high_on;
         end
      end

      property p_low_trip;
         @(posedge sys_clk_i) disable iff (reset_i)
         (cfg[i].mode == spr_pkg::MODE_LOW && cfg[i].low_en && pressure_i < cfg[i].low_thr)
         |=> relay_o[i] && sp_lamp_o[i];
      endproperty
      a_low_trip: assert property (p_low_trip) else $error("low trip missed");

      property p_high_trip;
         @(posedge sys_clk_i) disable iff (reset_i)
         (cfg[i].mode == spr_pkg::MODE_HIGH && cfg[i].high_en && pressure_i > cfg[i].high_thr)
         |=> relay_o[i] && sp_lamp_o[i];
      endproperty
      a_high_trip: assert property (p_high_trip) else $error("high trip missed");

      property p_comb_trip;
         @(posedge sys_clk_i) disable iff (reset_i)
         (cfg[i].mode == spr_pkg::MODE_BOTH && cfg[i].high_en && cfg[i].low_en &&
          (pressure_i > cfg[i].high_thr || pressure_i < cfg[i].low_thr)) |=> relay_o[i];
      endproperty
      a_comb_trip: assert property (p_comb_trip) else $error("combined trip missed");

      property p_bottom_quiet;
         @(posedge sys_clk_i) disable iff (reset_i)
         (!relay_o[i] && cfg[i].mode == spr_pkg::MODE_LOW && cfg[i].low_thr == 16'h0000)
         |=> !relay_o[i];
      endproperty
      a_bottom_quiet: assert property (p_bottom_quiet) else $error("relay at range bottom");

      property p_show_value;
         @(posedge sys_clk_i) disable iff (reset_i)
         (adj[i] && (i == 0 || !adj[0])) |=> meas_value_o == $past(sel_thr[i]);
      endproperty
      a_show_value: assert property (p_show_value) else $error("threshold not shown");

      property p_enter_adjust;
         @(posedge sys_clk_i) disable iff (reset_i)
         (state == spr_pkg::ST_MEAS && btn && !version_show_o) |=> state == spr_pkg::ST_SHOW
         ##1 (cfg[i].low_hyst == spr_pkg::HYST_RST && cfg[i].high_hyst == spr_pkg::HYST_RST);
      endproperty
      a_enter_adjust: assert property (p_enter_adjust) else $error("adjust entry wrong");

      property p_fine_step;
         @(posedge sys_clk_i) disable iff (reset_i)
         (state == spr_pkg::ST_WAIT && btn && tmr < 16'(FINE_MS) && dir_up[i] &&
          sel_thr[i] != spr_pkg::THR_MAX && !wr_pend) |=> sel_thr[i] == $past(sel_thr[i]) + 16'h0001;
      endproperty
      a_fine_step: assert property (p_fine_step) else $error("fine step wrong");

      property p_reverse;
         @(posedge sys_clk_i) disable iff (reset_i)
         (state == spr_pkg::ST_WAIT && btn && tmr >= 16'(FINE_MS)) |=> dir_up[i] != $past(dir_up[i]);
      endproperty
      a_reverse: assert property (p_reverse) else $error("direction not reversed");

      property p_store;
         @(posedge sys_clk_i) disable iff (reset_i)
         (state == spr_pkg::ST_WAIT && !btn && tmr > 16'(SAVE_MS))
         |=> nv_store_o[i] && state == spr_pkg::ST_MEAS ##1 !nv_store_o[i];
      endproperty
      a_store: assert property (p_store) else $error("store not issued");

      property p_hold_low;
         @(posedge sys_clk_i) disable iff (reset_i)
         (low_on[i] && low_act && 18'(pressure_i) <= low_rel) |=> low_on[i];
      endproperty
      a_hold_low: assert property (p_hold_low) else $error("relay chatter");
   end

   // Channel and global read words
   always_comb begin
      rd_word = 32'h0000_0000;
      if (bus_addr == spr_pkg::GLOBAL_STAT) begin
         rd_word = {16'h0000, FW_VERSION, 5'h00, fault_soft_i, fault_fatal_i, version_show_o};
      end else if (bus_addr[7:5] == 3'h0) begin
         unique case (bus_addr[3:0])
            spr_pkg::CH_LOW_THR: rd_word = {16'h0000, cfg[bus_addr[4]].low_thr};
            spr_pkg::CH_HIGH_THR: rd_word = {16'h0000, cfg[bus_addr[4]].high_thr};
            spr_pkg::CH_CFG: rd_word = {8'h00, cfg[bus_addr[4]].high_hyst,
               cfg[bus_addr[4]].low_hyst, 4'h0, cfg[bus_addr[4]].high_en,
               cfg[bus_addr[4]].low_en, cfg[bus_addr[4]].mode};
            spr_pkg::CH_STAT: rd_word = {27'h000_0000, dir_up[bus_addr[4]], adj[bus_addr[4]],
               high_on[bus_addr[4]], low_on[bus_addr[4]], relay_o[bus_addr[4]]};
            default: rd_word = 32'h0000_0000;
         endcase
      end
   end

   // Writes finish with no wait; reads take one wait state so a preceding write is seen
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         bus_addr <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
         wr_pend <= 1'b0;
         if (rd_pend) begin
            hrdata_o <= rd_word;
            rd_pend <= 1'b0;
            hreadyout_o <= 1'b1;
         end else if (hsel_i && htrans_i[1] && hready_i) begin
            bus_addr <= (haddr_i[31:8] == 24'h00_0000) ? haddr_i[7:0] : 8'hFF;
            wr_pend <= hwrite_i;
            rd_pend <= !hwrite_i;
            hreadyout_o <= hwrite_i;
         end
      end
   end
endmodule : spr_top

// File: test/spr_plant.sv
// Partner model: pressure front end, two pushbuttons and fault sources.
// Assumes bench commands on sys_clk_i; outputs launch one edge later, like sensor logic.
`timescale 1ns/10ps
module spr_plant (
   // Clock
   input wire logic sys_clk_i,
   // Bench commands
   input wire logic [15:0] p_cmd_i,
   input wire logic [1:0] btn_cmd_i,
   input wire logic [1:0] flt_cmd_i,
   // Device side
   output logic [15:0] pressure_o,
   output logic [1:0] btn_o,
   output logic [1:0] flt_o
);
   initial begin
      pressure_o = 16'h0000;
      btn_o = 2'b00;
      flt_o = 2'b00;
   end
   always @(posedge sys_clk_i) begin
      pressure_o <= p_cmd_i;
      btn_o <= btn_cmd_i;
      flt_o <= flt_cmd_i;
   end
endmodule : spr_plant

// File: test/tb_spr_top.sv
// Self-checking bench for spr_top with shortened timing parameters.
// Assumes an AHB-Lite single-word master here and spr_plant on the sensor side.
`timescale 1ns/10ps
module tb_spr_top;
   logic sys_clk_i, reset_i, hsel, hwrite, hready, hresp, green, red, vshow;
   logic [1:0] htrans, btn_cmd, flt_cmd, btn, flt, relay, lamp, ind, store;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [2:0] hsize;
   logic [15:0] p_cmd, pressure, meas;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   spr_top #(.MS_CYCLES(10), .SHOW_MS(20), .SAVE_MS(20), .FINE_MS(8), .STEP_MS(2),
      .VERSION_MS(5), .BLINK_MS(2)) u_spr_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
      .hrdata_o(hrdata), .pressure_i(pressure), .fault_fatal_i(flt[0]), .fault_soft_i(flt[1]),
      .setpoint_one_btn_i(btn[0]), .setpoint_two_btn_i(btn[1]), .relay_o(relay),
      .sp_lamp_o(lamp), .switch_ind_o(ind), .nv_store_o(store), .meas_value_o(meas),
      .status_lamp_green_o(green), .status_lamp_red_o(red), .version_show_o(vshow));
   spr_plant u_spr_plant (.sys_clk_i(sys_clk_i), .p_cmd_i(p_cmd), .btn_cmd_i(btn_cmd),
      .flt_cmd_i(flt_cmd), .pressure_o(pressure), .btn_o(btn), .flt_o(flt));
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task finish_test;
      $display("mismatches %0d, comparisons %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task cyc_n(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : cyc_n
   // Values read right after the edge are the ones sampled at it
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hsize <= 3'h2;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge sys_clk_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task t_reset;
      chk(vshow, 1, "version shown");
      chk(relay, 0, "relay at reset");
      bus(0, 8'h00, 0);
      chk(rd, 0, "low threshold");
      bus(0, 8'h18, 0);
      chk(rd, 32'h000A_0A0C, "config");
      bus(0, 8'h30, 0);
      chk(rd, 0, "unmapped read");
      chk(hresp, 0, "response");
      bus(0, 8'h20, 0);
      chk(rd, 32'h0000_0101, "global status");
      cyc_n(60);
      chk(vshow, 0, "version gone");
   endtask : t_reset
   task t_low;
      bus(1, 8'h00, 32'h0000_0064);
      bus(0, 8'h00, 0);
      chk(rd, 32'h0000_0064, "threshold readback");
      // Upper address bits set must not alias onto channel 0
      bus(0, 32'h0000_0100, 0);
      chk(rd, 0, "high address unmapped");
      p_cmd <= 16'h0063;
      cyc_n(4);
      chk(relay, 2'b01, "low trip");
      chk(lamp, 2'b01, "lamp");
      p_cmd <= 16'h006E;
      cyc_n(4);
      chk(relay[0], 1, "inside margin");
      p_cmd <= 16'h006F;
      cyc_n(4);
      chk(relay[0], 0, "low release");
   endtask : t_low
   task t_high;
      bus(1, 8'h14, 32'h0000_03E8);
      bus(1, 8'h18, 32'h000A_0A0D);
      p_cmd <= 16'h03E9;
      cyc_n(4);
      chk(relay[1], 1, "high trip");
      p_cmd <= 16'h0384;
      cyc_n(4);
      chk(relay[1], 1, "inside margin");
      p_cmd <= 16'h0383;
      cyc_n(4);
      chk(relay[1], 0, "high release");
      bus(1, 8'h10, 32'h0000_0032);
      bus(1, 8'h18, 32'h000A_0A0E);
      p_cmd <= 16'h03E9;
      cyc_n(4);
      chk(relay[1], 1, "both upper");
      p_cmd <= 16'h0200;
      cyc_n(4);
      chk(relay[1], 0, "both between");
      p_cmd <= 16'h0031;
      cyc_n(4);
      chk(relay[1], 1, "both lower");
      p_cmd <= 16'h0200;
      cyc_n(4);
   endtask : t_high
   task t_btn;
      int k;
      logic last;
      bus(1, 8'h08, 32'h0014_140C);
      btn_cmd <= 2'b01;
      cyc_n(10);
      chk(meas, 16'h0064, "threshold shown");
      bus(0, 8'h08, 0);
      chk(rd, 32'h000A_0A0C, "hysteresis restored");
      k = 0;
      repeat (100) begin
         last = ind[0];
         @(posedge sys_clk_i);
         if (ind[0] !== last) k++;
      end
      chk(k >= 2, 1, "indicator blinks");
      cyc_n(200);
      chk(meas > 16'h0064, 1, "threshold ramps");
      btn_cmd <= 2'b00;
      k = 0;
      repeat (400) begin
         @(posedge sys_clk_i);
         if (store[0] === 1'b1) k++;
      end
      chk(k, 1, "one store pulse");
      chk(meas, 16'h0200, "pressure back");
   endtask : t_btn
   // Channel 1 sits in combined mode: short press, fine step, reverse, store
   task t_btn2;
      int k;
      btn_cmd <= 2'b10;
      cyc_n(10);
      chk(meas, 16'h0032, "second threshold shown");
      btn_cmd <= 2'b00;
      cyc_n(20);
      btn_cmd <= 2'b10;
      cyc_n(12);
      chk(meas, 16'h0033, "fine step");
      btn_cmd <= 2'b00;
      cyc_n(120);
      btn_cmd <= 2'b10;
      cyc_n(50);
      chk(meas < 16'h0033, 1, "direction reversed");
      btn_cmd <= 2'b00;
      bus(0, 8'h14, 0);
      chk(rd, 32'h0000_03E8, "upper untouched");
      k = 0;
      repeat (300) begin
         @(posedge sys_clk_i);
         if (store[1] === 1'b1) k++;
      end
      chk(k, 1, "second store pulse");
   endtask : t_btn2
   task t_fault;
      int k;
      logic last;
      flt_cmd <= 2'b01;
      cyc_n(4);
      chk({green, red}, 2'b01, "fatal red");
      flt_cmd <= 2'b00;
      cyc_n(4);
      chk({green, red}, 2'b10, "green");
      flt_cmd <= 2'b10;
      cyc_n(4);
      chk(green, 0, "soft not green");
      k = 0;
      repeat (80) begin
         last = red;
         @(posedge sys_clk_i);
         if (red !== last) k++;
      end
      chk(k >= 2, 1, "soft red blinks");
      flt_cmd <= 2'b00;
   endtask : t_fault
   // Whole run needs under 2000 cycles
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         finish_test;
      end
   end
   initial begin
      reset_i = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      {p_cmd, btn_cmd, flt_cmd} = '0;
      cyc_n(4);
      reset_i <= 1'b0;
      cyc_n(1);
      t_reset;
      t_low;
      t_high;
      t_btn;
      t_btn2;
      t_fault;
      finish_test;
   end
endmodule : tb_spr_top
